/* File: rtl/ctpd_map.svh */
`ifndef CTPD_MAP_SVH
`define CTPD_MAP_SVH
// ************************************************************
// Register map and field layout
// ************************************************************
`define CTPD_UNITS      2
`define CTPD_CNT_W      8
`define CTPD_BUS_W      32
`define CTPD_ADDR_W     5
`define CTPD_UNIT_BIT   4
`define CTPD_REG_CTRL   4'h0
`define CTPD_REG_PERIOD 4'h4
`define CTPD_REG_DUTY   4'h8
`define CTPD_REG_COUNT  4'hc
`define CTPD_FF_BIT     7
`define CTPD_CKS_HI     6
`define CTPD_CKS_LO     4
`define CTPD_RUN_BIT    3
`define CTPD_MODE_HI    2
`define CTPD_MODE_LO    0
`define CTPD_WIDE_BIT   2
`define CTPD_CTRL_RST   8'h00
`define CTPD_PER_RST    8'h00
// ************************************************************
// Mode and clock select codes
// ************************************************************
`define CTPD_MD_TMR     3'h0
`define CTPD_MD_DIV     3'h1
`define CTPD_MD_PWM     3'h2
`define CTPD_MD_T16     3'h4
`define CTPD_CK_D11     3'h0
`define CTPD_CK_D7      3'h1
`define CTPD_CK_D5      3'h2
`define CTPD_CK_D3      3'h3
`define CTPD_CK_D1      3'h5
`define CTPD_CK_D0      3'h6
`define CTPD_CK_PIN     3'h7
`define CTPD_PRE_W      11
`define CTPD_TAP_D7     7
`define CTPD_TAP_D5     5
`define CTPD_TAP_D3     3
`endif

/* File: rtl/ctpd_pkg.sv */
`include "ctpd_map.svh"
package ctpd_pkg;
   typedef enum logic [4:0]
   {
      UM_IDLE   = 5'h01,
      UM_PERIOD = 5'h02,
      UM_DIV    = 5'h04,
      UM_PWM    = 5'h08,
      UM_CASC   = 5'h10
   } ctpd_umode_t;
   typedef enum logic [1:0]
   {
      BUS_IDLE  = 2'h1,
      BUS_RDATA = 2'h2
   } ctpd_bus_t;
endpackage : ctpd_pkg

/* File: rtl/ctpd_timer.sv */
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "ctpd_map.svh"
module ctpd_timer
   import ctpd_pkg::*;
#(
   parameter int W = `CTPD_CNT_W
)(
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic [`CTPD_ADDR_W-1:0]     avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [`CTPD_BUS_W-1:0]      avs_writedata,
   output logic      [`CTPD_BUS_W-1:0]      avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic [`CTPD_UNITS-1:0]      event_input_pin,
   output logic      [`CTPD_UNITS-1:0]      divider_output_pin,
   output logic      [`CTPD_UNITS-1:0]      pwm_output_pin,
   output logic      [`CTPD_UNITS-1:0]      match_interrupt
);
   localparam int NU = `CTPD_UNITS;

   logic [W-1:0]            ctrl       [NU];
   logic [W-1:0]            next_ctrl  [NU];
   logic [W-1:0]            per        [NU];
   logic [W-1:0]            next_per   [NU];
   logic [W-1:0]            cnt        [NU];
   logic [W-1:0]            duty_act   [NU];
   logic [W-1:0]            duty_hold  [NU];
   ctpd_umode_t             umode      [NU];
   logic [NU-1:0]           run;
   logic [NU-1:0]           tick;
   logic [NU-1:0]           own_tick;
   logic [NU-1:0]           ovf;
   logic [NU-1:0]           ff;
   logic [NU-1:0]           irq_unit;
   logic [NU-1:0]           ff_load;
   logic [NU-1:0]           duty_wr;
   logic [NU-1:0]           wr_ctrl;
   logic [NU-1:0]           ev_prev;
   logic [NU-1:0]           next_ev_prev;
   logic [NU-1:0]           fall;
   logic [`CTPD_PRE_W-1:0]  pre;
   logic [`CTPD_PRE_W-1:0]  next_pre;
   ctpd_bus_t               bus_st;
   ctpd_bus_t               next_bus_st;
   logic [`CTPD_BUS_W-1:0]  rdata;
   logic [`CTPD_BUS_W-1:0]  next_rdata;
   logic [`CTPD_BUS_W-1:0]  rd_mux;
   logic                    sel_u;
   logic [`CTPD_UNIT_BIT-1:0] reg_ofs;
   logic                    wide;
   logic                    wide_tmr;
   logic                    match16;

   // ************************************************************
   // Clock source selection
   // ************************************************************
   function automatic logic ctpd_tick(input logic [2:0]             cks,
                                      input logic [`CTPD_PRE_W-1:0] p,
                                      input logic                   f);
      logic t;
      t = 1'b0;
      case (cks)
         `CTPD_CK_D11: t = &p;
         `CTPD_CK_D7:  t = &p[`CTPD_TAP_D7-1:0];
         `CTPD_CK_D5:  t = &p[`CTPD_TAP_D5-1:0];
         `CTPD_CK_D3:  t = &p[`CTPD_TAP_D3-1:0];
         `CTPD_CK_D1:  t = p[0];
         `CTPD_CK_D0:  t = 1'b1;
         `CTPD_CK_PIN: t = f;
         default:      t = 1'b0;
      endcase
      return t;
   endfunction : ctpd_tick

   // The pin is taken as synchronous, so one register is enough for edges.
   assign fall = ev_prev & ~event_input_pin;

   always_comb
   begin
      next_pre     = `CTPD_PRE_W'(pre + 1'b1);
      next_ev_prev = event_input_pin;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pre     <= '0;
         ev_prev <= '0;
      end
      else
      begin
         pre     <= next_pre;
         ev_prev <= next_ev_prev;
      end
   end

   // ************************************************************
   // Avalon-MM slave
   // ************************************************************
   assign sel_u           = avs_address[`CTPD_UNIT_BIT];
   assign reg_ofs         = avs_address[`CTPD_UNIT_BIT-1:0];
   assign avs_waitrequest = avs_read & (bus_st == BUS_IDLE);
   assign avs_readdata    = rdata;

   always_comb
   begin
      case (reg_ofs)
         `CTPD_REG_CTRL:   rd_mux = `CTPD_BUS_W'(ctrl[sel_u]);
         `CTPD_REG_PERIOD: rd_mux = `CTPD_BUS_W'(per[sel_u]);
         `CTPD_REG_DUTY:   rd_mux = `CTPD_BUS_W'(duty_hold[sel_u]);
         `CTPD_REG_COUNT:  rd_mux = `CTPD_BUS_W'(cnt[sel_u]);
         default:          rd_mux = '0;
      endcase
   end

   always_comb
   begin
      next_bus_st = bus_st;
      next_rdata  = rdata;
      unique case (bus_st)
         BUS_IDLE:
         begin
            if (avs_read)
            begin
               next_bus_st = BUS_RDATA;
               next_rdata  = rd_mux;
            end
         end
         BUS_RDATA:
            next_bus_st = BUS_IDLE;
         default:
            next_bus_st = BUS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_st <= BUS_IDLE;
         rdata  <= '0;
      end
      else
      begin
         bus_st <= next_bus_st;
         rdata  <= next_rdata;
      end
   end

   // ************************************************************
   // Control and period registers
   // ************************************************************
   always_comb
   begin
      for (int i = 0; i < NU; i++)
      begin
         next_ctrl[i] = ctrl[i];
         next_per[i]  = per[i];
         if (wr_ctrl[i])
            next_ctrl[i] = avs_writedata[W-1:0];
         if (avs_write && sel_u == 1'(i) && reg_ofs == `CTPD_REG_PERIOD)
            next_per[i] = avs_writedata[W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NU; i++)
         begin
            ctrl[i] <= `CTPD_CTRL_RST;
            per[i]  <= `CTPD_PER_RST;
         end
      end
      else
      begin
         for (int i = 0; i < NU; i++)
         begin
            ctrl[i] <= next_ctrl[i];
            per[i]  <= next_per[i];
         end
      end
   end

   // ************************************************************
   // Cascade control
   // ************************************************************
   assign wide     = ctrl[1][`CTPD_WIDE_BIT];
   assign wide_tmr = ctrl[1][`CTPD_MODE_HI:`CTPD_MODE_LO] == `CTPD_MD_T16;
   assign match16  = run[1] & wide_tmr
                     & ({cnt[1], cnt[0]} == {per[1], per[0]});
   assign match_interrupt = {irq_unit[1] | match16, irq_unit[0]};

   // ************************************************************
   // Counter units
   // ************************************************************
   genvar u;
   generate
      for (u = 0; u < NU; u++)
      begin : g_unit
         assign wr_ctrl[u]  = avs_write & (sel_u == 1'(u)) & (reg_ofs == `CTPD_REG_CTRL);
         assign duty_wr[u]  = avs_write & (sel_u == 1'(u)) & (reg_ofs == `CTPD_REG_DUTY);
         // A stopping write does not preset the flip-flop; only a write seen while stopped presets it.
         assign ff_load[u]  = wr_ctrl[u] & ~ctrl[u][`CTPD_RUN_BIT];
         assign own_tick[u] = ctpd_tick(ctrl[u][`CTPD_CKS_HI:`CTPD_CKS_LO], pre, fall[u]);
         assign divider_output_pin[u] = ~ff[u];
         assign pwm_output_pin[u]     = ~ff[u];

         always_comb
         begin
            if (wide)
               umode[u] = UM_CASC;
            else
            begin
               case (ctrl[u][`CTPD_MODE_HI:`CTPD_MODE_LO])
                  `CTPD_MD_TMR: umode[u] = UM_PERIOD;
                  `CTPD_MD_DIV: umode[u] = UM_DIV;
                  `CTPD_MD_PWM: umode[u] = UM_PWM;
                  default:      umode[u] = UM_IDLE;
               endcase
            end
         end

         if (u == 0)
         begin : g_lo
            assign tick[u] = own_tick[u];
            assign run[u]  = wide ? ctrl[1][`CTPD_RUN_BIT] : ctrl[0][`CTPD_RUN_BIT];
         end
         else
         begin : g_hi
            assign tick[u] = wide ? ovf[0] : own_tick[u];
            assign run[u]  = ctrl[u][`CTPD_RUN_BIT];
         end

         ctpd_unit #(.W(W)) u_cnt (
            .mclk       (mclk),
            .rst_b      (rst_b),
            .tick       (tick[u]),
            .run        (run[u]),
            .umode      (umode[u]),
            .period     (per[u]),
            .ext_clr    (match16),
            .ff_load    (ff_load[u]),
            .ff_val     (avs_writedata[`CTPD_FF_BIT]),
            .duty_wr    (duty_wr[u]),
            .duty_wdata (avs_writedata[W-1:0]),
            .count      (cnt[u]),
            .ff         (ff[u]),
            .duty_act   (duty_act[u]),
            .duty_hold  (duty_hold[u]),
            .ovf        (ovf[u]),
            .match_irq  (irq_unit[u])
         );
      end
   endgenerate

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   AST_EVT_COUNT: assert property (
      (umode[1] == UM_PERIOD && run[1] && !avs_write && fall[1] && !irq_unit[1]
       && ctrl[1][`CTPD_CKS_HI:`CTPD_CKS_LO] == `CTPD_CK_PIN)
      |=> cnt[1] == W'($past(cnt[1]) + 1'b1))
      else $error("event edge not counted");
   AST_MATCH_CLR: assert property (
      (irq_unit[0] && !wide) |=> cnt[0] == '0)
      else $error("counter not cleared after match");
   AST_DIV_TOGGLE: assert property (
      (umode[0] == UM_DIV && irq_unit[0] && !avs_write) |=> ff[0] != $past(ff[0]))
      else $error("divider output did not toggle");
   AST_PRESET: assert property (
      (wr_ctrl[0] && !ctrl[0][`CTPD_RUN_BIT])
      |=> divider_output_pin[0] == !$past(avs_writedata[`CTPD_FF_BIT]))
      else $error("preset did not reach divider pin");
   AST_STOP_HOLD: assert property (
      (wr_ctrl[0] && ctrl[0][`CTPD_RUN_BIT] && !avs_writedata[`CTPD_RUN_BIT])
      |=> $stable(ff[0]) ##0 $stable(pwm_output_pin[0]))
      else $error("stopping write moved the output");
   AST_STOP_CLR: assert property (
      (wr_ctrl[0] && !avs_writedata[`CTPD_RUN_BIT] && !wide) |=> ##1 cnt[0] == '0)
      else $error("stop did not clear counter");
   AST_PWM_OVF: assert property (
      (umode[0] == UM_PWM && ovf[0] && !avs_write)
      |=> (ff[0] != $past(ff[0])) && cnt[0] == '0 && duty_act[0] == $past(duty_hold[0]))
      else $error("pwm overflow mishandled");
   AST_WIDE_CLK: assert property (
      (wide && run[1] && !match16 && !avs_write)
      |=> cnt[1] == W'($past(cnt[1]) + $past(ovf[0])))
      else $error("upper unit not clocked by lower overflow");
   AST_WIDE_MATCH: assert property (
      match16 |-> match_interrupt[1] ##1 (cnt[0] == '0 && cnt[1] == '0))
      else $error("wide match did not clear both counters");
   AST_DUTY_READ: assert property (
      (avs_read && avs_waitrequest && reg_ofs == `CTPD_REG_DUTY && !avs_write)
      |=> avs_readdata == `CTPD_BUS_W'(duty_hold[$past(sel_u)]))
      else $error("duty read not from holding stage");
   AST_BUS_RD: assert property (
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("read wait longer than one cycle");

   COV_DIV:   cover property (umode[0] == UM_DIV && irq_unit[0]);
   COV_EVT:   cover property (umode[1] == UM_PERIOD && fall[1] ##[1:20] irq_unit[1]);
   COV_PWM:   cover property (umode[0] == UM_PWM && ovf[0] && duty_wr[0]);
   COV_WIDE:  cover property (match16);
endmodule : ctpd_timer

/* File: rtl/ctpd_unit.sv */
`timescale 1ns/1ps
`include "ctpd_map.svh"
module ctpd_unit
   import ctpd_pkg::*;
#(
   parameter int W = `CTPD_CNT_W
)(
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         tick,
   input  wire logic         run,
   input  wire ctpd_umode_t  umode,
   input  wire logic [W-1:0] period,
   input  wire logic         ext_clr,
   input  wire logic         ff_load,
   input  wire logic         ff_val,
   input  wire logic         duty_wr,
   input  wire logic [W-1:0] duty_wdata,
   output logic      [W-1:0] count,
   output logic              ff,
   output logic      [W-1:0] duty_act,
   output logic      [W-1:0] duty_hold,
   output logic              ovf,
   output logic              match_irq
);
   logic [W-1:0] next_count;
   logic [W-1:0] next_duty_act;
   logic [W-1:0] next_duty_hold;
   logic         next_ff;
   logic         period_eq;
   logic         duty_hit;
   logic         pwm_ovf;

   // ************************************************************
   // Compare and overflow events
   // ************************************************************
   assign ovf       = run & tick & (count == {W{1'b1}});
   assign period_eq = run & ((umode == UM_PERIOD) | (umode == UM_DIV))
                      & (count == period);
   assign duty_hit  = run & (umode == UM_PWM) & tick
                      & (W'(count + 1'b1) == duty_act);
   assign pwm_ovf   = (umode == UM_PWM) & ovf;
   assign match_irq = period_eq | pwm_ovf;

   // ************************************************************
   // Counter, output flip-flop and duty stages
   // ************************************************************
   always_comb
   begin
      next_count     = count;
      next_ff        = ff;
      next_duty_hold = duty_hold;
      next_duty_act  = duty_act;
      if (!run || ext_clr || period_eq)
         next_count = '0;
      else if (tick)
         next_count = W'(count + 1'b1);
      // Presets are only offered while stopped, so a stopping write moves the pin only if a toggle falls due in the same cycle.
      if (ff_load)
         next_ff = ff_val;
      else if ((period_eq && umode == UM_DIV) || duty_hit || pwm_ovf)
         next_ff = ~ff;
      if (duty_wr)
         next_duty_hold = duty_wdata;
      // A write landing on the overflow cycle moves the older holding value.
      if (pwm_ovf || !run)
         next_duty_act = duty_hold;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count     <= '0;
         ff        <= 1'b0;
         duty_hold <= '0;
         duty_act  <= '0;
      end
      else
      begin
         count     <= next_count;
         ff        <= next_ff;
         duty_hold <= next_duty_hold;
         duty_act  <= next_duty_act;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   AST_PWM_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
      (umode == UM_PWM && run && !pwm_ovf) |=> $stable(duty_act))
      else $error("duty compare changed without overflow");
   AST_PWM_LOAD: assert property (@(posedge mclk) disable iff (!rst_b)
      pwm_ovf |=> duty_act == $past(duty_hold))
      else $error("duty not transferred at overflow");
   AST_PWM_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
      (duty_hit && !ff_load) |=> (ff != $past(ff)) ##0 (count == duty_act))
      else $error("pwm duty match did not toggle");
endmodule : ctpd_unit

/* File: sim/cascadable_timer_pwm_divider_test.sv */
`timescale 1ns/1ps
`include "ctpd_map.svh"
module cascadable_timer_pwm_divider_test;
   import ctpd_pkg::*;
   typedef struct packed
   {
      logic [`CTPD_ADDR_W-1:0] addr;
      logic                    wr;
      logic [7:0]              data;
   } ctpd_row_t;
   logic                      mclk;
   logic                      rst_b;
   logic                      avs_read;
   logic                      avs_write;
   logic [`CTPD_ADDR_W-1:0]   avs_address;
   logic [`CTPD_BUS_W-1:0]    avs_writedata;
   logic [`CTPD_BUS_W-1:0]    avs_readdata;
   logic [`CTPD_BUS_W-1:0]    rd;
   logic                      avs_waitrequest;
   logic [`CTPD_UNITS-1:0]    event_input_pin;
   logic [`CTPD_UNITS-1:0]    divider_output_pin;
   logic [`CTPD_UNITS-1:0]    pwm_output_pin;
   logic [`CTPD_UNITS-1:0]    match_interrupt;
   logic                      src_pin;
   logic                      p;
   int                        err_total = 0;
   int                        n_tests = 0;
   int                        tmo = 0;
   int                        cyc;
   int                        hi;
   int                        h1;
   int                        i;
   ctpd_row_t                 rows [11];

   // Only the upper unit counts events; the lower event line stays idle high.
   assign event_input_pin = {src_pin, 1'b1};

   ctpd_timer dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .event_input_pin(event_input_pin), .divider_output_pin(divider_output_pin),
      .pwm_output_pin(pwm_output_pin), .match_interrupt(match_interrupt));

   ctpd_event_src src (.mclk(mclk), .rst_b(rst_b), .pin(src_pin));

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   // Waitrequest and read data are taken at the rising edge that completes the
   // transfer, so the request is released only after the slave has seen it.
   task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= {24'h0, d};
      avs_write     <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [4:0] a);
      @(posedge mclk);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd

   // Counts cycles and high pin cycles up to and including the next match pulse.
   task automatic meas(input int u);
      cyc = 0;
      hi  = 0;
      do
      begin
         @(negedge mclk);
         cyc++;
         if (pwm_output_pin[u] === 1'b1)
            hi++;
      end
      while (match_interrupt[u] !== 1'b1);
   endtask : meas

   task final_report;
      $display("mismatches %0d, comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   always @(posedge mclk)
   begin
      tmo <= tmo + 1;
      if (tmo == 20000)
      begin
         err_total++;
         final_report();
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      rows = '{'{5'h00, 1'b0, 8'h00}, '{5'h14, 1'b0, 8'h00}, '{5'h18, 1'b0, 8'h00},
               '{5'h04, 1'b1, 8'h5a}, '{5'h04, 1'b0, 8'h5a}, '{5'h0c, 1'b1, 8'h33},
               '{5'h0c, 1'b0, 8'h00}, '{5'h02, 1'b1, 8'h77}, '{5'h02, 1'b0, 8'h00},
               '{5'h18, 1'b1, 8'ha5}, '{5'h18, 1'b0, 8'ha5}};
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk(divider_output_pin, 2'b11, "pins after reset");
      for (i = 0; i < 11; i++)
      begin
         if (rows[i].wr)
            bus_wr(rows[i].addr, rows[i].data);
         else
         begin
            bus_rd(rows[i].addr);
            chk(rd, {24'h0, rows[i].data}, "register row");
         end
      end
      // Divider: period written while stopped, fastest clock.
      bus_wr(5'h04, 8'h02);
      bus_wr(5'h00, 8'h69);
      meas(0);
      meas(0);
      h1 = hi;
      chk(cyc, 3, "divider interval");
      meas(0);
      chk(h1 + hi, 3, "divider half periods");
      bus_wr(5'h00, 8'h61);
      p = divider_output_pin[0];
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      chk(divider_output_pin[0], p, "pin held after stop");
      bus_rd(5'h0c);
      chk(rd, 32'h0, "count cleared by stop");
      bus_wr(5'h00, 8'he1);
      @(negedge mclk);
      chk(divider_output_pin[0], 1'b0, "preset one");
      bus_wr(5'h00, 8'h61);
      @(negedge mclk);
      chk(divider_output_pin[0], 1'b1, "preset zero drives high");
      // Divider on the divide-by-eight tap: matches lie period times eight cycles apart.
      bus_wr(5'h00, 8'h39);
      meas(0);
      meas(0);
      chk(cyc, 16, "prescaled divider interval");
      bus_wr(5'h00, 8'h31);
      // Event counter on the upper unit, preset bit kept at zero.
      bus_wr(5'h14, 8'h03);
      bus_wr(5'h10, 8'h78);
      src.pulses(2, 4);
      repeat (4) @(posedge mclk);
      bus_rd(5'h1c);
      chk(rd, 32'h2, "edges counted");
      fork
         src.pulses(1, 2);
         meas(1);
      join
      bus_rd(5'h1c);
      chk(rd, 32'h0, "cleared at match");
      bus_wr(5'h10, 8'h70);
      // PWM with preset one, duty rewritten just after a match.
      bus_wr(5'h08, 8'h40);
      bus_wr(5'h00, 8'hea);
      meas(0);
      bus_wr(5'h08, 8'h80);
      bus_rd(5'h08);
      chk(rd, 32'h80, "duty read shows holding stage");
      meas(0);
      chk(hi, 192, "old duty still active");
      meas(0);
      chk(cyc, 256, "pwm period");
      chk(hi, 128, "new duty after match");
      // The shared port latch lies outside this block; the pins are read as if it were one.
      bus_wr(5'h00, 8'h6a);
      // Sixteen-bit cascade, lower byte written first.
      bus_wr(5'h00, 8'h60);
      bus_wr(5'h04, 8'h02);
      bus_wr(5'h14, 8'h01);
      bus_wr(5'h10, 8'h0c);
      meas(1);
      meas(1);
      chk(cyc, 259, "cascade interval");
      // Reset in mid-run.
      @(posedge mclk);
      rst_b <= 1'b0;
      @(negedge mclk);
      chk(match_interrupt, 2'b00, "no match in reset");
      chk(pwm_output_pin, 2'b11, "pins in reset");
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      bus_rd(5'h10);
      chk(rd, 32'h0, "control after reset");
      final_report();
   end
endmodule : cascadable_timer_pwm_divider_test

/* File: sim/ctpd_event_src.sv */
`timescale 1ns/1ps
// ************************************************************
// External event source for the event counter input
// ************************************************************
module ctpd_event_src
(
   input  wire logic mclk,
   input  wire logic rst_b,
   output logic      pin
);
   initial pin = 1'b1;

   // The line idles high, so every pulse is one falling edge followed by a rise.
   task automatic pulses(input int n, input int hold);
      int h;
      h = (hold < 2) ? 2 : hold;
      repeat (n)
      begin
         repeat (h) @(posedge mclk);
         pin <= 1'b0;
         repeat (h) @(posedge mclk);
         pin <= 1'b1;
      end
   endtask : pulses
endmodule : ctpd_event_src
